// ==== cap_timer_cfg.svh ====
// register offsets, field positions, reset values and divider counts
`ifndef CAP_TIMER_CFG_SVH
`define CAP_TIMER_CFG_SVH
`define OFF_MODE 4'h0
`define OFF_COUNT 4'h4
`define OFF_RISE 4'h8
`define OFF_FALL 4'hC
`define ADDR_MODE 12'h000
`define ADDR_COUNT 12'h004
`define ADDR_RISE 12'h008
`define ADDR_FALL 12'h00C
`define ADDR_CTRL 12'h010
`define ADDR_IRQ 12'h014
`define ADDR_PWR 12'h018
`define MODE_RESET 8'h00
`define MODE_OVH_BIT 7
`define MODE_OVL_BIT 6
`define MODE_OVERFLOW_IRQ_ENABLE_BIT 5
`define MODE_EDGE_BIT 4
`define CTRL_RESET 8'h01
`define CTRL_STBY_BIT 0
`define CTRL_FILT_BIT 1
`define CTRL_PIN_BIT 2
`define IRQ_FLAG_BIT 0
`define IRQ_EN_BIT 1
`define FILTER_STAGES 5
`define DIV_WIDTH 6
`define WDIV_WIDTH 2
`endif

// ==== cap_timer_pkg.sv ====
// types shared by the capture interval timer
package cap_timer_pkg;
  typedef enum logic [1:0] {
    CLK_DIV64 = 2'b00,
    CLK_DIV32 = 2'b01,
    CLK_DIV2 = 2'b10,
    CLK_WATCH4 = 2'b11
  } clk_sel_t;
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_FALL = 2'b01,
    CLR_RISE = 2'b10,
    CLR_BOTH = 2'b11
  } clr_sel_t;
  typedef enum logic [2:0] {
    PM_ACTIVE = 3'b000,
    PM_SLEEP = 3'b001,
    PM_WATCH = 3'b010,
    PM_SUBACTIVE = 3'b011,
    PM_SUBSLEEP = 3'b100,
    PM_STANDBY = 3'b101
  } power_mode_t;
  typedef struct packed {
    logic overflow_high_flag;
    logic overflow_low_flag;
    logic overflow_irq_enable;
    logic irq_edge_select;
    clr_sel_t counter_clear;
    clk_sel_t clock_select;
  } timer_mode_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wr_req_t;
endpackage : cap_timer_pkg

// ==== cap_timer.sv ====
// capture / interval timer with noise filter and axi4-lite registers
// Operation
// - standby control bit 0 halts timer, 1 runs it; resets to 1
// - filter: five series latches, output updates only when all agree
// - filter off samples on system clock, on samples on counter clock
// - after reset filter output settles once five low samples seen
// - filtered edge reaches capture logic five sampling clocks late
// - toggling filter or pin function may make a spurious edge
// - pin function bit 1 gives capture timer, 0 interval timer
// - reset clears mode register, counter and both capture registers
// - 8-bit up-counter, counting system clock over 64 after reset
// - clock select picks sys/64, sys/32, sys/2 or watch/4
// - select codes 00 /64, 01 /32, 10 /2, 11 watch/4
// - rising edge captures into rise register, falling into fall
// - selected capture edge sets irq flag; cpu signalled if enabled
// - edge select 0 rising, 1 falling; resets to 0
// - counter cleared on rising, falling or both capture edges
// - clear codes 00 none, 01 falling, 10 rising, 11 both
// - capture mode overflow sets high or low flag by input level
// - interval mode wraps FF to 00 and sets low overflow flag
// - overflow with overflow enable sets irq flag; cpu if enabled
// - overflow flags hardware set; software clears by reading 1 then writing 0
// - watch/4 tap is synchronised to system clock in active/sleep
// - watch mode: run only with watch/4 selected, else halt
// - subactive/subsleep: run only with watch/4 and subclock watch/2
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`include "cap_timer_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module cap_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic capture_pin,
  input wire logic watch_clk,
  input wire cap_timer_pkg::power_mode_t power_mode,
  input wire logic sub_is_watch_div2,
  output logic timer_irq
);
  import cap_timer_pkg::*;

  // bus-side and timer state
  logic aw_held_r, w_held_r;
  wr_req_t wr_r;
  timer_mode_t timer_mode_reg_r;
  logic [7:0] timer_counter_r, rise_capture_reg_r, fall_capture_reg_r;
  logic timer_standby_ctl_r, filter_enable_r, capture_pin_function_r;
  logic timer_irq_flag_r, timer_irq_enable_r;
  logic ovh_seen_r, ovl_seen_r;
  logic [`DIV_WIDTH-1:0] div_r;
  logic [`WDIV_WIDTH-1:0] wdiv_r;
  logic wclk_s1_r, wclk_s2_r, wclk_s3_r;
  logic tap_prev_r;
  logic [`FILTER_STAGES-1:0] filt_sh_r;
  logic filt_out_r, filt_init_r, cap_prev_r;

  // address match helper, used for reads and writes
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a[11:2] == r[11:2]);
  endfunction : hit

  // write strobe assembled from held address and data
  logic wr_go;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  logic wr_lane0;
  assign wr_lane0 = wr_go && wr_r.strb[0];

  // tap selection; watch tap is synchronised to aclk (two flops, then edge)
  logic tap_lvl, tap_fall;
  always_comb
  begin
    case (timer_mode_reg_r.clock_select)
      CLK_DIV64: tap_lvl = div_r[5];
      CLK_DIV32: tap_lvl = div_r[4];
      CLK_DIV2: tap_lvl = div_r[0];
      CLK_WATCH4: tap_lvl = wdiv_r[1];
      default: tap_lvl = div_r[5];
    endcase
  end
  assign tap_fall = tap_prev_r && !tap_lvl;

  // power-mode gating of the whole timer
  logic run_en;
  logic watch_sel;
  assign watch_sel = (timer_mode_reg_r.clock_select == CLK_WATCH4);
  always_comb
  begin
    case (power_mode)
      PM_ACTIVE, PM_SLEEP: run_en = 1'b1;
      PM_WATCH: run_en = watch_sel;
      PM_SUBACTIVE, PM_SUBSLEEP:
        run_en = watch_sel && sub_is_watch_div2;
      PM_STANDBY: run_en = 1'b0;
      default: run_en = 1'b0;
    endcase
    if (!timer_standby_ctl_r)
      run_en = 1'b0;
  end

  // mode register writable only where the cpu is running
  logic mode_wr_ok;
  assign mode_wr_ok = timer_standby_ctl_r && (power_mode == PM_ACTIVE ||
                      power_mode == PM_SUBACTIVE);

  // count enable: one pulse per falling edge of the chosen tap
  logic cnt_tick, sample_tick;
  assign cnt_tick = run_en && tap_fall;
  // filter samples on rising edge of tap, or every aclk when bypassed
  assign sample_tick = run_en && (filter_enable_r ? (!tap_prev_r && tap_lvl)
                       : 1'b1);

  // pin forced low when not configured as capture input
  logic pin_in;
  assign pin_in = capture_pin_function_r && capture_pin;
  // agreement judged on the word after this sample, so no sixth-sample lag
  logic [`FILTER_STAGES-1:0] filt_nxt;
  assign filt_nxt = {filt_sh_r[`FILTER_STAGES-2:0], pin_in};

  // filtered or direct capture level
  logic cap_lvl;
  assign cap_lvl = filter_enable_r ? filt_out_r : pin_in;

  // edge detect; a function bit toggle may show up as an edge here
  logic rise_ev, fall_ev;
  assign rise_ev = run_en && cap_lvl && !cap_prev_r;
  assign fall_ev = run_en && !cap_lvl && cap_prev_r;

  logic clr_ev;
  always_comb
  begin
    case (timer_mode_reg_r.counter_clear)
      CLR_NONE: clr_ev = 1'b0;
      CLR_FALL: clr_ev = fall_ev;
      CLR_RISE: clr_ev = rise_ev;
      CLR_BOTH: clr_ev = rise_ev || fall_ev;
      default: clr_ev = 1'b0;
    endcase
  end

  logic ovf_ev;
  assign ovf_ev = cnt_tick && !clr_ev && (timer_counter_r == 8'hFF);
  logic set_ovh, set_ovl;
  assign set_ovh = ovf_ev && capture_pin_function_r && cap_lvl;
  assign set_ovl = ovf_ev && !(capture_pin_function_r && cap_lvl);

  logic edge_irq;
  assign edge_irq = timer_mode_reg_r.irq_edge_select ? fall_ev : rise_ev;

  // system clock divider; free running
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  // watch clock synchroniser and divide-by-4 on its rising edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wclk_s1_r <= 1'b0;
      wclk_s2_r <= 1'b0;
      wclk_s3_r <= 1'b0;
      wdiv_r <= '0;
    end
    else
    begin
      wclk_s1_r <= watch_clk;
      wclk_s2_r <= wclk_s1_r;
      wclk_s3_r <= wclk_s2_r;
      if (wclk_s2_r && !wclk_s3_r)
        wdiv_r <= wdiv_r + 1'b1; // up to one aclk of jitter
    end
  end

  // previous tap level for edge finding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tap_prev_r <= 1'b0;
    else
      tap_prev_r <= tap_lvl;
  end

  // noise filter; output undefined-free: held low until five low samples
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_sh_r <= '1;
      filt_out_r <= 1'b0;
      filt_init_r <= 1'b0;
    end
    else if (sample_tick && filter_enable_r)
    begin
      filt_sh_r <= filt_nxt;
      if (&filt_nxt)
      begin
        if (filt_init_r)
          filt_out_r <= 1'b1; // short highs never fill
      end
      else if (~|filt_nxt)
      begin
        filt_out_r <= 1'b0;
        filt_init_r <= 1'b1;
      end
    end
  end
  // five-deep agreement gives the five-sample delay

  // capture level history
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cap_prev_r <= 1'b0;
    else if (run_en)
      cap_prev_r <= cap_lvl;
  end

  // counter; clear wins over increment
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer_counter_r <= 8'h00;
    else if (run_en && capture_pin_function_r && clr_ev)
      timer_counter_r <= 8'h00;
    else if (cnt_tick)
      timer_counter_r <= timer_counter_r + 8'h01;
  end

  // capture registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rise_capture_reg_r <= 8'h00;
      fall_capture_reg_r <= 8'h00;
    end
    else if (capture_pin_function_r)
    begin
      if (rise_ev)
        rise_capture_reg_r <= timer_counter_r;
      if (fall_ev)
        fall_capture_reg_r <= timer_counter_r;
    end
  end

  // mode register with hardware-set flags; set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_mode_reg_r <= `MODE_RESET;
    end
    else
    begin
      if (wr_lane0 && hit(wr_r.addr, `ADDR_MODE) && mode_wr_ok)
      begin
        timer_mode_reg_r.overflow_irq_enable <= wr_r.data[`MODE_OVERFLOW_IRQ_ENABLE_BIT];
        timer_mode_reg_r.irq_edge_select <= wr_r.data[`MODE_EDGE_BIT];
        timer_mode_reg_r.counter_clear <= clr_sel_t'(wr_r.data[3:2]);
        timer_mode_reg_r.clock_select <= clk_sel_t'(wr_r.data[1:0]);
        // only a 0 after reading 1 clears
        if (!wr_r.data[`MODE_OVH_BIT] && ovh_seen_r)
          timer_mode_reg_r.overflow_high_flag <= 1'b0;
        if (!wr_r.data[`MODE_OVL_BIT] && ovl_seen_r)
          timer_mode_reg_r.overflow_low_flag <= 1'b0;
      end
      if (set_ovh)
        timer_mode_reg_r.overflow_high_flag <= 1'b1;
      if (set_ovl)
        timer_mode_reg_r.overflow_low_flag <= 1'b1;
    end
  end

  // read-as-1 tracking for the overflow flag clear handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovh_seen_r <= 1'b0;
      ovl_seen_r <= 1'b0;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `ADDR_MODE))
      begin
        ovh_seen_r <= timer_mode_reg_r.overflow_high_flag;
        ovl_seen_r <= timer_mode_reg_r.overflow_low_flag;
      end
      else if (wr_lane0 && hit(wr_r.addr, `ADDR_MODE))
      begin
        ovh_seen_r <= 1'b0;
        ovl_seen_r <= 1'b0;
      end
    end
  end

  // control bits: standby, filter enable, pin function
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_standby_ctl_r <= 1'b1;
      filter_enable_r <= 1'b0;
      capture_pin_function_r <= 1'b0;
    end
    else if (wr_lane0 && hit(wr_r.addr, `ADDR_CTRL))
    begin
      timer_standby_ctl_r <= wr_r.data[`CTRL_STBY_BIT];
      filter_enable_r <= wr_r.data[`CTRL_FILT_BIT];
      capture_pin_function_r <= wr_r.data[`CTRL_PIN_BIT];
    end
  end

  // interrupt request flag and enable; event set beats software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_irq_flag_r <= 1'b0;
      timer_irq_enable_r <= 1'b0;
      timer_irq <= 1'b0;
    end
    else
    begin
      if (wr_lane0 && hit(wr_r.addr, `ADDR_IRQ))
      begin
        timer_irq_enable_r <= wr_r.data[`IRQ_EN_BIT];
        if (!wr_r.data[`IRQ_FLAG_BIT])
          timer_irq_flag_r <= 1'b0;
      end
      if (capture_pin_function_r && edge_irq)
        timer_irq_flag_r <= 1'b1;
      if ((set_ovh || set_ovl) && timer_mode_reg_r.overflow_irq_enable)
        timer_irq_flag_r <= 1'b1;
      timer_irq <= timer_irq_flag_r && timer_irq_enable_r;
    end
  end

  // axi write channels: take address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        wr_r.addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wr_r.data <= s_axi_wdata;
        wr_r.strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (hit(wr_r.addr, `ADDR_MODE) ||
                        hit(wr_r.addr, `ADDR_CTRL) ||
                        hit(wr_r.addr, `ADDR_IRQ)) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read data mux
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case ({2'b00, s_axi_araddr[11:2]})
      `ADDR_MODE >> 2: rd_val[7:0] = timer_mode_reg_r;
      `ADDR_COUNT >> 2: rd_val[7:0] = timer_counter_r;
      `ADDR_RISE >> 2: rd_val[7:0] = rise_capture_reg_r;
      `ADDR_FALL >> 2: rd_val[7:0] = fall_capture_reg_r;
      `ADDR_CTRL >> 2: rd_val[2:0] = {capture_pin_function_r,
                                        filter_enable_r, timer_standby_ctl_r};
      `ADDR_IRQ >> 2: rd_val[1:0] = {timer_irq_enable_r, timer_irq_flag_r};
      `ADDR_PWR >> 2: rd_val[0] = run_en;
      default: rd_ok = 1'b0;
    endcase
  end

  // axi read channel; one read at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : cap_timer
`default_nettype wire

// ==== cap_timer_assertions.sv ====
// concurrent checks on the timer's bus and interrupt ports
`timescale 1ns/1ns
`default_nettype none
module cap_timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  // a stalled answer must stay put until the master takes it
  a_bvalid_hold: assert property (disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  a_rvalid_hold: assert property (disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before rready");
  // read answer one cycle after the address is taken
  a_read_answer: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_awready_pulse: assert property (disable iff (!aresetn)
    s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_arready_pulse: assert property (disable iff (!aresetn)
    s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  // holes in the map answer with an error and no data
  a_unmapped_read: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] > 10'h006
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_read: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] <= 10'h006
    |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0)
    else $error("mapped read refused or too wide");
  // no disable here: reset itself is the cause
  a_reset_quiet: assert property (
    !aresetn |=> !timer_irq && !s_axi_rvalid && !s_axi_bvalid)
    else $error("outputs active after reset");
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_irq_rise: cover property ($rose(timer_irq));
endmodule : cap_timer_checker
bind cap_timer cap_timer_checker i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_irq(timer_irq)
);
`default_nettype wire

// ==== pulse_source.sv ====
// behavioural pulse source standing on the capture input
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
  input wire logic aclk,
  output var logic pin
);
  initial pin = 1'b0;
  // hold a level n clocks, at least two; short highs pass so the filter sees noise
  task automatic drive(input logic v, input int n);
    int k;
    k = (n < 2) ? 2 : n;
    @(posedge aclk);
    pin <= v;
    repeat (k - 1) @(posedge aclk);
  endtask : drive
endmodule : pulse_source
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the capture interval timer
`timescale 1ns/1ns
`default_nettype none
`include "cap_timer_cfg.svh"
module testbench;
  import cap_timer_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic pin;
  logic watch_clk = 1'b0;
  power_mode_t power_mode = PM_ACTIVE;
  logic sub_div2 = 1'b0;
  logic timer_irq;
  logic [31:0] seed = 32'h00015488;
  logic [31:0] rd;
  logic [31:0] c0;
  logic [1:0] rsp;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int slow = 0;
  int h;
  int l;
  int waits[4] = '{512, 256, 13, 100};
  power_mode_t pm[7] = '{PM_ACTIVE, PM_WATCH, PM_WATCH, PM_SUBACTIVE,
    PM_SUBACTIVE, PM_SUBSLEEP, PM_STANDBY};
  logic [1:0] pclk[7] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3};
  logic psub[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic prun[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  always #50 aclk = ~aclk;
  // watch clock edges never meet the rising system clock edges
  always #160 watch_clk = ~watch_clk;
  cap_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_pin(pin), .watch_clk(watch_clk),
    .power_mode(power_mode), .sub_is_watch_div2(sub_div2),
    .timer_irq(timer_irq));
  pulse_source i_src (.aclk(aclk), .pin(pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // flag expected from edge select and the level just driven
  function automatic logic want(input int s, input int v);
    return (s == 1) != (v == 1);
  endfunction : want
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // hang guard, well above the expected run length
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input int t);
    checked++;
    if (^g === 1'bx || g > e + t || g + t < e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // write: both channels offered together, bready late when slow
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (slow == 0);
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n == slow) bready <= 1'b1;
    end
    while (!(bvalid === 1'b1 && bready === 1'b1));
    bready <= 1'b0;
    rsp = bresp;
  endtask : wr
  task automatic rdt(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (slow == 0);
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n == slow) rready <= 1'b1;
    end
    while (!(rvalid === 1'b1 && rready === 1'b1));
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
  endtask : rdt
  task automatic rc(input logic [11:0] a, input logic [31:0] e,
    input int t);
    rdt(a);
    chk(rd, e, t);
  endtask : rc
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`ADDR_MODE, 32'h0, 0);
    rc(`ADDR_COUNT, 32'h0, 1);
    rc(`ADDR_RISE, 32'h0, 0);
    rc(`ADDR_FALL, 32'h0, 0);
    rc(`ADDR_CTRL, 32'h1, 0);
    slow = 5;
    rdt(12'h01C);
    chk({30'h0, rsp}, 32'h2, 0);
    wr(12'h020, 32'h0);
    chk({30'h0, rsp}, 32'h2, 0);
    slow = 0;
    $display("test reset done");
    // each select code over about eight ticks of its tap
    for (int i = 0; i < 4; i++)
    begin
      wr(`ADDR_MODE, i);
      rdt(`ADDR_COUNT);
      c0 = rd;
      repeat (waits[i]) @(posedge aclk);
      rc(`ADDR_COUNT, c0 + 8, 2);
    end
    $display("test clock select done");
    // interval mode with pin high: only the low flag may rise
    wr(`ADDR_IRQ, 32'h2);
    wr(`ADDR_MODE, 32'h22);
    i_src.drive(1'b1, 600);
    rc(`ADDR_MODE, 32'h62, 0);
    chk({31'h0, timer_irq}, 32'h1, 0);
    rdt(`ADDR_COUNT);
    // start clearing just after a wrap, far from the next one
    repeat ((256 - int'(rd[7:0])) * 2 + 8) @(posedge aclk);
    wr(`ADDR_MODE, 32'hC2);
    rc(`ADDR_MODE, 32'h42, 0);
    wr(`ADDR_MODE, 32'h02);
    rc(`ADDR_MODE, 32'h02, 0);
    $display("test interval done");
    // capture mode, clear on both edges, widths from the lfsr
    wr(`ADDR_CTRL, 32'h5);
    wr(`ADDR_MODE, 32'h0E);
    i_src.drive(1'b0, 40);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      h = 20 + int'(seed[6:0]);
      seed = lfsr(seed);
      l = 20 + int'(seed[6:0]);
      i_src.drive(1'b1, h);
      i_src.drive(1'b0, l);
      i_src.drive(1'b1, 30);
      rc(`ADDR_FALL, h / 2, 2);
      rc(`ADDR_RISE, l / 2, 2);
      i_src.drive(1'b0, 30);
    end
    $display("test capture done");
    for (int s = 0; s < 2; s++)
      for (int v = 1; v >= 0; v--)
      begin
        wr(`ADDR_MODE, (s == 1) ? 32'h12 : 32'h02);
        wr(`ADDR_IRQ, 32'h2);
        i_src.drive(v[0], 20);
        rc(`ADDR_IRQ, {30'h0, 1'b1, want(s, v)}, 0);
        chk({31'h0, timer_irq}, {31'h0, want(s, v)}, 0);
      end
    $display("test edge select done");
    // filter on; the enable change may fake an edge, so flush first
    wr(`ADDR_MODE, 32'h02);
    wr(`ADDR_CTRL, 32'h7);
    repeat (30) @(posedge aclk);
    wr(`ADDR_IRQ, 32'h2);
    i_src.drive(1'b1, 6);
    i_src.drive(1'b0, 40);
    rc(`ADDR_IRQ, 32'h2, 0);
    i_src.drive(1'b1, 4);
    rc(`ADDR_IRQ, 32'h2, 0);
    i_src.drive(1'b1, 30);
    rc(`ADDR_IRQ, 32'h3, 0);
    $display("test filter done");
    // module standby: counter and mode both frozen
    wr(`ADDR_CTRL, 32'h4);
    rdt(`ADDR_COUNT);
    c0 = rd;
    i_src.drive(1'b0, 40);
    rc(`ADDR_COUNT, c0, 0);
    wr(`ADDR_MODE, 32'h03);
    rc(`ADDR_MODE, 32'h02, 0);
    wr(`ADDR_CTRL, 32'h5);
    $display("test standby done");
    for (int i = 0; i < 7; i++)
    begin
      power_mode <= PM_ACTIVE;
      wr(`ADDR_MODE, {30'h0, pclk[i]});
      power_mode <= pm[i];
      sub_div2 <= psub[i];
      rdt(`ADDR_COUNT);
      c0 = rd;
      repeat (60) @(posedge aclk);
      rdt(`ADDR_COUNT);
      chk({31'h0, rd != c0}, {31'h0, prun[i]}, 0);
    end
    $display("test power modes done");
    results();
  end
endmodule : testbench
`default_nettype wire
